// >>> rtl/jbt_pkg.sv
// Constants, opcodes and TAP state codes of the boundary scan port
//
// Summary of operation
// R1: Five dedicated test pins: mode select, clock, reset, data in, data out.
// R2: Bypass instruction puts one shift stage between data in and data out.
// R3: External test makes the boundary register drive and observe the pins.
// R4: Sample captures pin inputs while the part keeps working normally.
// R5: Sample also lets shifted values preload the latched output stages.
// R6: Clamp selects bypass while boundary register keeps driving the outputs.
// R7: Identification instruction puts the identification register on the path.
// R8: Identification register is 32 bits, fixed, with maker, part, version.
// R9: Capture state with identification loads the fixed code for shifting.
// R10: Bit 31 sits nearest data in, bit 0 nearest data out, leaves first.
// R11: Test-logic-reset forces the instruction to identification.
// R12: Low test reset forces test-logic-reset at once, without test clock.
// R13: Tester should keep the port in reset while the part runs normally.
// R14: Sixteen-state controller steps on rising test clock under mode select.
// R15: Data out changes on falling edges, driven only while shifting.
package jbt_pkg;

  // Boundary register geometry
  localparam int N_IN    = 4;
  localparam int N_OUT   = 4;
  localparam int BSR_LEN = N_IN + N_OUT;

  // Instruction register
  localparam int         IR_LEN     = 4;
  localparam logic [3:0] OP_EXTEST  = 4'h0;
  localparam logic [3:0] OP_SAMPLE  = 4'h1;
  localparam logic [3:0] OP_CLAMP   = 4'h2;
  localparam logic [3:0] OP_IDCODE  = 4'h3;
  localparam logic [3:0] OP_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identification code fields, values arbitrary
  localparam int          ID_LEN     = 32;
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h0A5C;
  localparam logic [10:0] ID_MAKER   = 11'h02A;
  localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Toggle handshake synchroniser depth
  localparam int TGL_SYNC = 3;

  typedef enum logic [15:0]
  {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jbt_tap_e;

endpackage

// >>> rtl/jbt_tap.sv
// Boundary scan test access port with TAP controller and data registers
`timescale 1ns/1ps

module jbt_tap
(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       tck,
  input  wire logic                       trst_n,
  input  wire logic                       tms,
  input  wire logic                       tdi,
  output logic                            tdo,
  output logic                            tdo_oe,
  input  wire logic [jbt_pkg::N_OUT-1:0]  core_out,
  output logic      [jbt_pkg::N_IN-1:0]   core_in,
  input  wire logic [jbt_pkg::N_IN-1:0]   pin_in,
  output logic      [jbt_pkg::N_OUT-1:0]  pin_out
);
  import jbt_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  jbt_tap_e               state_ff;
  jbt_tap_e               nxt_state;
  logic [IR_LEN-1:0]      ir_sh_ff;
  logic [IR_LEN-1:0]      ir_ff;
  logic                   byp_ff;
  logic [ID_LEN-1:0]      id_sh_ff;
  logic [BSR_LEN-1:0]     bsr_sh_ff;
  logic [BSR_LEN-1:0]     bsr_upd_ff;
  logic [N_IN-1:0]        pin_s1_ff;
  logic [N_IN-1:0]        pin_s2_ff;
  logic [N_OUT-1:0]       cout_s1_ff;
  logic [N_OUT-1:0]       cout_s2_ff;
  logic                   drive_tck_ff;
  logic                   upd_tgl_ff;
  logic                   tdo_ff;
  logic                   tdo_oe_ff;
  logic                   nxt_tdo;
  logic                   in_shift;
  logic                   bsr_sel;
  logic [N_IN-1:0]        cin_s1_ff;
  logic [N_IN-1:0]        cin_s2_ff;
  logic                   drive_s1_ff;
  logic                   drive_s2_ff;
  logic [TGL_SYNC-1:0]    tgl_sync_ff;
  logic [N_OUT-1:0]       upd_core_ff;
  logic [N_OUT-1:0]       pin_out_ff;

  // Boundary register sits on the path under external test or sample
  assign bsr_sel  = (ir_ff == OP_EXTEST) || (ir_ff == OP_SAMPLE);
  assign in_shift = (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);

  // ***************************************************************
  // TAP controller
  // ***************************************************************
  always_comb
  begin
    nxt_state = ST_TLR;
    unique case (state_ff)
      ST_TLR:    nxt_state = tms ? ST_TLR    : ST_RTI;      // [R14]
      ST_RTI:    nxt_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nxt_state = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
      default:   nxt_state = ST_TLR;
    endcase
  end

  // Test reset low forces reset state without the clock
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      state_ff <= ST_TLR;                                   // [R12]
    else
      state_ff <= nxt_state;                                // [R14]
  end

  // ***************************************************************
  // Instruction register
  // ***************************************************************
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_sh_ff <= IR_CAPTURE;
    else if (state_ff == ST_CAP_IR)
      ir_sh_ff <= IR_CAPTURE;
    else if (state_ff == ST_SH_IR)
      ir_sh_ff <= {tdi, ir_sh_ff[IR_LEN-1:1]};
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_ff <= OP_IDCODE;
    else if (state_ff == ST_TLR)
      ir_ff <= OP_IDCODE;                                   // [R11]
    else if (state_ff == ST_UPD_IR)
      ir_ff <= ir_sh_ff;
  end

  // ***************************************************************
  // Bypass and identification registers
  // ***************************************************************
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      byp_ff <= 1'b0;
    else if (state_ff == ST_CAP_DR)
      byp_ff <= 1'b0;
    else if (state_ff == ST_SH_DR)
      byp_ff <= tdi;                                        // [R2] [R6]
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      id_sh_ff <= ID_VALUE;
    else if (state_ff == ST_CAP_DR && ir_ff == OP_IDCODE)
      id_sh_ff <= ID_VALUE;                                 // [R8] [R9]
    else if (state_ff == ST_SH_DR && ir_ff == OP_IDCODE)
      id_sh_ff <= {tdi, id_sh_ff[ID_LEN-1:1]};              // [R10]
  end

  // ***************************************************************
  // Boundary register, test clock side
  // ***************************************************************
  // Pins and core outputs are foreign to the test clock
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      pin_s1_ff  <= '0;
      pin_s2_ff  <= '0;
      cout_s1_ff <= '0;
      cout_s2_ff <= '0;
    end
    else
    begin
      pin_s1_ff  <= pin_in;
      pin_s2_ff  <= pin_s1_ff;
      cout_s1_ff <= pin_out_ff;
      cout_s2_ff <= cout_s1_ff;
    end
  end

  // Input cells low, output cells high; bit 0 nearest data out
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bsr_sh_ff <= '0;
    else if (state_ff == ST_CAP_DR && bsr_sel)
      bsr_sh_ff <= {cout_s2_ff, pin_s2_ff};                 // [R3] [R4]
    else if (state_ff == ST_SH_DR && bsr_sel)
      bsr_sh_ff <= {tdi, bsr_sh_ff[BSR_LEN-1:1]};
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      bsr_upd_ff <= '0;
    else if (state_ff == ST_UPD_DR && bsr_sel)
      bsr_upd_ff <= bsr_sh_ff;                              // [R5]
  end

  // Event to core side: toggle on the same test clock edge as each output latch update
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      upd_tgl_ff <= 1'b0;
    else if (state_ff == ST_UPD_DR && bsr_sel)
      upd_tgl_ff <= ~upd_tgl_ff;
  end

  // Pins follow the output latches under external test and clamp
  // Set at the Update-IR edge itself, the test clock may stop right after
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      drive_tck_ff <= 1'b0;
    else if (state_ff == ST_TLR)
      drive_tck_ff <= 1'b0;
    else if (state_ff == ST_UPD_IR)
      drive_tck_ff <= (ir_sh_ff == OP_EXTEST)               // [R3]
                      || (ir_sh_ff == OP_CLAMP);            // [R6]
  end

  // ***************************************************************
  // Serial output on falling test clock
  // ***************************************************************
  always_comb
  begin
    nxt_tdo = byp_ff;
    if (state_ff == ST_SH_IR)
      nxt_tdo = ir_sh_ff[0];
    else if (ir_ff == OP_IDCODE)
      nxt_tdo = id_sh_ff[0];                                // [R7] [R10]
    else if (bsr_sel)
      nxt_tdo = bsr_sh_ff[0];                               // [R3]
    else
      nxt_tdo = byp_ff;                                     // [R2] [R6]
  end

  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else
    begin
      tdo_ff    <= nxt_tdo;                                 // [R15]
      tdo_oe_ff <= in_shift;                                // [R15]
    end
  end

  // ***************************************************************
  // Core clock side
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      drive_s1_ff <= 1'b0;
      drive_s2_ff <= 1'b0;
      tgl_sync_ff <= '0;
    end
    else
    begin
      drive_s1_ff <= drive_tck_ff;
      drive_s2_ff <= drive_s1_ff;
      tgl_sync_ff <= {tgl_sync_ff[TGL_SYNC-2:0], upd_tgl_ff};
    end
  end

  // Latches are stable long before the toggle is seen
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      upd_core_ff <= '0;
    else if (tgl_sync_ff[TGL_SYNC-1] ^ tgl_sync_ff[TGL_SYNC-2])
      upd_core_ff <= bsr_upd_ff[BSR_LEN-1:N_IN];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_out_ff <= '0;
    else if (drive_s2_ff)
      pin_out_ff <= upd_core_ff;                            // [R3] [R6]
    else
      pin_out_ff <= core_out;                               // [R4]
  end

  // Core always sees the pins, so sampling never disturbs it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cin_s1_ff <= '0;
      cin_s2_ff <= '0;
    end
    else
    begin
      cin_s1_ff <= pin_in;
      cin_s2_ff <= cin_s1_ff;                               // [R4]
    end
  end

  assign tdo     = tdo_ff;                                  // [R1]
  assign tdo_oe  = tdo_oe_ff;
  assign core_in = cin_s2_ff;
  assign pin_out = pin_out_ff;

  // ***************************************************************
  // Checks
  // ***************************************************************
  chk_tms_reset: assert property ( // [R14]
    @(posedge tck) disable iff (!trst_n)
    tms [*5] |=> (state_ff == ST_TLR))
    else $error("five mode-select highs did not reach reset state");

  chk_trst_async: assert property ( // [R12]
    @(posedge core_clk) !trst_n |-> (state_ff == ST_TLR) && !tdo_oe_ff)
    else $error("state not reset while test reset low");

  chk_ir_reset: assert property ( // [R11]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_TLR) |=> (ir_ff == OP_IDCODE))
    else $error("reset state did not force identification");

  chk_bypass_shift: assert property ( // [R2]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_SH_DR && ir_ff == OP_BYPASS)
      ##1 (state_ff == ST_SH_DR) |-> (tdo_ff == $past(tdi, 1)))
    else $error("bypass path is not one stage");

  chk_id_capture: assert property ( // [R9]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_CAP_DR && ir_ff == OP_IDCODE)
      |=> (id_sh_ff == ID_VALUE) && (tdo_ff == ID_VALUE[0]))
    else $error("identification code not captured");

  chk_id_order: assert property ( // [R10]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_SH_DR && ir_ff == OP_IDCODE)
      |=> (id_sh_ff[ID_LEN-1] == $past(tdi))
          && (id_sh_ff[ID_LEN-2:0] == $past(id_sh_ff[ID_LEN-1:1])))
    else $error("identification shift order wrong");

  chk_tdo_enable: assert property ( // [R15]
    @(posedge tck) disable iff (!trst_n)
    tdo_oe_ff == in_shift)
    else $error("data out enable not tied to shift states");

  chk_sample_capture: assert property ( // [R4]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_CAP_DR && ir_ff == OP_SAMPLE)
      |=> (bsr_sh_ff[N_IN-1:0] == $past(pin_s2_ff)))
    else $error("sample did not capture pin inputs");

  chk_preload: assert property ( // [R5]
    @(posedge tck) disable iff (!trst_n)
    (state_ff == ST_UPD_DR && ir_ff == OP_SAMPLE)
      |=> (bsr_upd_ff == $past(bsr_sh_ff)))
    else $error("preload did not reach output latches");

  chk_pin_normal: assert property ( // [R4]
    @(posedge core_clk) disable iff (rst)
    !drive_s2_ff |=> (pin_out_ff == $past(core_out)))
    else $error("pins not following core in normal mode");

  chk_pin_drive: assert property ( // [R3]
    @(posedge core_clk) disable iff (rst)
    drive_s2_ff |=> (pin_out_ff == $past(upd_core_ff)))
    else $error("pins not driven by boundary latches");

endmodule // jbt_tap

// >>> testbench/jbt_tester.sv
// Board tester model driving the test pins of the scan port
`timescale 1ns/1ps

module jbt_tester
(
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last_ff;
  logic tdo_w;
  logic oe_rise;

  // Port held in reset until the first frame
  initial
  begin
    tck    = 1'b0;
    trst_n = 1'b1;
    tms    = 1'b1;
    tdi    = 1'b0;
    last_ff = 1'b0;
    oe_rise = 1'b0;
    // Real falling edge once the port logic is waiting for it
    #1 trst_n = 1'b0;
  end

  // Released line shows the inverse of its last driven level
  always @(posedge tck)
    if (tdo_oe)
      last_ff <= tdo;
  assign tdo_w = tdo_oe ? tdo : ~last_ff;

  // One test clock period, clock stands low between calls
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    q = tdo_w;
    oe_rise = tdo_oe;
    #15 tck = 1'b0;
  endtask

  // Asynchronous reset, then to run-test/idle
  task automatic hard_reset();
    logic q;
    trst_n = 1'b0;
    #7 trst_n = 1'b1;
    #8 step(1'b0, 1'b0, q);
  endtask

  // Five mode-select ones reach reset, then idle
  task automatic soft_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // Full IR or DR scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_all);
    logic q;
    dout = '0;
    oe_all = 1'b1;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      oe_all = oe_all & oe_rise;
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // jbt_tester

// >>> testbench/jbt_tap_tb.sv
// Self-checking testbench of the boundary scan port
`timescale 1ns/1ps

module jbt_tap_tb;
  import jbt_pkg::*;

  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic             tck;
  logic             trst_n;
  logic             tms;
  logic             tdi;
  logic             tdo;
  logic             tdo_oe;
  logic [N_OUT-1:0] core_out = '0;
  logic [N_IN-1:0]  core_in;
  logic [N_IN-1:0]  pin_in = '0;
  logic [N_OUT-1:0] pin_out;
  logic [31:0]      rnd = 32'h6A3B22A8;
  logic [31:0]      d;
  logic [7:0]       pre;
  logic             oe;
  int               fails = 0;
  int               checks = 0;
  int               cycles = 0;

  always #2 core_clk = ~core_clk;

  jbt_tap i_dut (.core_clk(core_clk), .rst(rst), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
    .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out));

  jbt_tester i_tst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic new_pins();
    rnd = lfsr(rnd);
    @(posedge core_clk);
    core_out <= rnd[7:4];
    pin_in <= rnd[3:0];
    repeat (6) @(posedge core_clk);
  endtask

  task automatic read_id();
    rnd = lfsr(rnd);
    i_tst.scan(1'b0, 32, rnd, d, oe);
    check(d, ID_VALUE);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      complete_run();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #13.3;
    i_tst.hard_reset();
    read_id();
    check(oe, 1'b1);
    check(tdo_oe, 1'b0);
    i_tst.scan(1'b1, 4, OP_BYPASS, d, oe);
    check(d[3:0], IR_CAPTURE);
    rnd = lfsr(rnd);
    i_tst.scan(1'b0, 8, rnd, d, oe);
    check(d[7:0], {rnd[6:0], 1'b0});
    i_tst.scan(1'b1, 4, OP_SAMPLE, d, oe);
    for (int k = 0; k < 4; k++)
    begin
      new_pins();
      pre = rnd[15:8];
      i_tst.scan(1'b0, BSR_LEN, pre, d, oe);
      check(d[7:0], {core_out, pin_in});
      check(pin_out, core_out);
      check(core_in, pin_in);
    end
    i_tst.scan(1'b1, 4, OP_EXTEST, d, oe);
    new_pins();
    check(pin_out, pre[7:4]);
    i_tst.scan(1'b0, BSR_LEN, pre, d, oe);
    check(d[7:0], {pre[7:4], pin_in});
    i_tst.scan(1'b1, 4, OP_CLAMP, d, oe);
    rnd = lfsr(rnd);
    i_tst.scan(1'b0, 8, rnd, d, oe);
    check(d[7:0], {rnd[6:0], 1'b0});
    new_pins();
    check(pin_out, pre[7:4]);
    i_tst.scan(1'b1, 4, OP_SAMPLE, d, oe);
    new_pins();
    check(pin_out, core_out);
    i_tst.scan(1'b1, 4, OP_BYPASS, d, oe);
    i_tst.step(1'b1, 1'b0, oe);
    i_tst.step(1'b0, 1'b0, oe);
    i_tst.step(1'b0, 1'b0, oe);
    i_tst.hard_reset();
    read_id();
    i_tst.scan(1'b1, 4, OP_BYPASS, d, oe);
    i_tst.soft_reset();
    read_id();
    complete_run();
  end
endmodule // jbt_tap_tb
